// File: fpc_pkg.sv
// Package for the flash protection control block.
// Assumes a single 100 MHz system clock domain.
package fpc_pkg;

  // --------------------------------------------------------------------
  // Protection modes
  // --------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    FPC_MODE_NONE = 2'h0,
    FPC_MODE_MID = 2'h1,
    FPC_MODE_STRICT = 2'h2
  } fpc_mode_t;

  // --------------------------------------------------------------------
  // Fetch source of a read instruction
  // --------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    FPC_SRC_PFLASH = 2'h0,
    FPC_SRC_DFLASH = 2'h1,
    FPC_SRC_ROM = 2'h2,
    FPC_SRC_OTHER = 2'h3
  } fpc_src_t;

  localparam logic [2:0] FPC_BOOT_MODE_PROT = 3'h6;
  localparam int FPC_PW_W = 64;
  localparam logic [1:0] FPC_MODE_RST = 2'h0;

endpackage

// File: fpc_erase_seq.sv
// Self-erase sequencer: walks both flash arrays after a password match.
// Assumes the flash macro answers each erase request with a done pulse.
`timescale 1ns/10ps
`default_nettype none
module fpc_erase_seq
  import fpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  output logic erase_p_req,
  output logic erase_d_req,
  input wire logic erase_done,
  output logic busy,
  output logic finished
);

  typedef enum logic [1:0] {FPC_ES_IDLE, FPC_ES_P, FPC_ES_D, FPC_ES_END}
    fpc_es_t;
  fpc_es_t state_ff;
  fpc_es_t nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      FPC_ES_IDLE: if (start) nxt_state = FPC_ES_P;
      FPC_ES_P: if (erase_done) nxt_state = FPC_ES_D;
      FPC_ES_D: if (erase_done) nxt_state = FPC_ES_END;
      FPC_ES_END: nxt_state = FPC_ES_END;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_ff <= FPC_ES_IDLE;
    else
      state_ff <= nxt_state;
  end

  assign erase_p_req = (state_ff == FPC_ES_P);
  assign erase_d_req = (state_ff == FPC_ES_D);
  assign busy = (state_ff == FPC_ES_P) || (state_ff == FPC_ES_D);
  assign finished = (state_ff == FPC_ES_END);

endmodule
`default_nettype wire

// File: fpc_top.sv
// Flash protection control: gates program, erase and read accesses.
// Assumes access requests come from the CPU on sys_clk; the boot loader
// request and password arrive already synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none

// How it works
// (R1) P-flash program/erase only when unprotected
// (R2) External data flash access always blocked
// (R3) Strict mode: data reads only from flash
// (R4) Mid mode: data erase needs fresh unlock
// (R5) Boot mode 6 enables or removes protection
// (R6) Host supplies stored password in mode 6
// (R7) Password match erases both flashes and password
// (R8) Protection stays until next reset after erase
// (R9) ROM variant protection can never be lifted
// (R10) ROM variant mode 6 gives protection error
// (R11) Protected ROM reads only from ROM code
// (R12) Same-cycle check; refused access changes nothing
module fpc_top
  import fpc_pkg::*;
#(
  parameter bit ROM_VARIANT = 1'b0,
  parameter int PW_W = FPC_PW_W
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] strap_mode,
  input wire logic rom_prot_en,
  input wire logic boot_req,
  input wire logic [2:0] boot_mode,
  input wire logic boot_set_prot,
  input wire logic [1:0] boot_new_mode,
  input wire logic [PW_W-1:0] boot_new_pw,
  input wire logic [PW_W-1:0] boot_pw,
  input wire logic [PW_W-1:0] stored_pw,
  input wire logic unlock_wr,
  input wire logic unlock_val,
  input wire logic p_prog_req,
  input wire logic p_erase_req,
  input wire logic d_prog_req,
  input wire logic d_erase_req,
  input wire logic d_read_req,
  input wire logic rom_read_req,
  input wire logic ext_d_req,
  input wire logic [1:0] fetch_src,
  input wire logic erase_done,
  output logic p_prog_ok,
  output logic p_erase_ok,
  output logic d_prog_ok,
  output logic d_erase_ok,
  output logic d_read_ok,
  output logic rom_read_ok,
  output logic ext_d_ok,
  output logic self_erase_p,
  output logic self_erase_d,
  output logic pw_store,
  output logic [PW_W-1:0] pw_store_val,
  output logic [1:0] store_mode,
  output logic prot_err_ff,
  output logic [1:0] prot_mode,
  output logic data_erase_unlock
);

  // ------------------------------------------------------------------
  // Protection state
  // ------------------------------------------------------------------
  logic [1:0] mode_ff;
  logic strap_taken_ff;
  logic unlock_ff;
  logic pw_hit;
  logic mode6_req;
  logic start_erase;
  logic es_busy;
  logic es_done;
  logic pw_store_ff;
  logic [1:0] store_mode_ff;
  logic [PW_W-1:0] pw_val_ff;

  assign mode6_req = boot_req && (boot_mode == FPC_BOOT_MODE_PROT); // R5
  // Host must present the stored password to release protection
  assign pw_hit = mode6_req && !boot_set_prot
    && (boot_pw == stored_pw) && (mode_ff != FPC_MODE_NONE)
    && !ROM_VARIANT; // R6 R9
  assign start_erase = pw_hit && !es_busy && !es_done; // R7

  // Mode caught from the stored strap after reset release; the flash
  // keeps protection until the next reset even after self-erase.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mode_ff <= FPC_MODE_RST;
      strap_taken_ff <= 1'b0;
    end
    else if (!strap_taken_ff)
    begin
      mode_ff <= strap_mode;
      strap_taken_ff <= 1'b1;
    end
  end

  // Set wins over clear: a write of one in the same cycle as an erase
  // re-arms for the next erase.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      unlock_ff <= 1'b0;
    else if (unlock_wr)
      unlock_ff <= unlock_val;
    else if (d_erase_ok)
      unlock_ff <= 1'b0; // R4
  end

  // Enabling protection in mode 6 stores the new mode and password;
  // it takes effect at the next reset through the strap.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pw_store_ff <= 1'b0;
      store_mode_ff <= FPC_MODE_RST;
      pw_val_ff <= '0;
    end
    else
    begin
      pw_store_ff <= mode6_req && boot_set_prot && !ROM_VARIANT; // R5
      if (mode6_req && boot_set_prot)
      begin
        store_mode_ff <= boot_new_mode;
        pw_val_ff <= boot_new_pw;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      prot_err_ff <= 1'b0;
    else if (ROM_VARIANT && mode6_req)
      prot_err_ff <= 1'b1; // R10
  end

  fpc_erase_seq u_erase
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(start_erase),
    .erase_p_req(self_erase_p),
    .erase_d_req(self_erase_d),
    .erase_done(erase_done),
    .busy(es_busy),
    .finished(es_done)
  );

  // ------------------------------------------------------------------
  // Access gating, combinational in the request cycle
  // ------------------------------------------------------------------
  wire prot_on = (mode_ff != FPC_MODE_NONE) || ROM_VARIANT; // R9
  wire strict = (mode_ff == FPC_MODE_STRICT);
  wire src_flash = (fetch_src == FPC_SRC_PFLASH)
    || (fetch_src == FPC_SRC_DFLASH);
  // Self-erase owns the array; CPU writes wait until it is over
  wire cpu_free = !es_busy;

  assign p_prog_ok = p_prog_req && !prot_on && cpu_free; // R1 R12
  assign p_erase_ok = p_erase_req && !prot_on && cpu_free; // R1 R12
  assign d_prog_ok = d_prog_req && !strict && cpu_free; // R12
  assign d_erase_ok = d_erase_req && cpu_free
    && ((mode_ff == FPC_MODE_NONE)
    || ((mode_ff == FPC_MODE_MID) && unlock_ff)); // R4 R12
  assign d_read_ok = d_read_req && (!strict || src_flash); // R3
  assign rom_read_ok = rom_read_req
    && (!rom_prot_en || (fetch_src == FPC_SRC_ROM)); // R11
  assign ext_d_ok = 1'b0; // R2

  assign pw_store = pw_store_ff;
  assign pw_store_val = pw_val_ff;
  assign store_mode = store_mode_ff;
  assign prot_mode = mode_ff; // R8
  assign data_erase_unlock = unlock_ff;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  p_refuse_a: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff != FPC_MODE_NONE) |-> !p_prog_ok && !p_erase_ok) // R1
    else $error("p-flash write while protected");
  ext_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    ext_d_req |-> !ext_d_ok) // R2
    else $error("external data flash access granted");
  strict_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (strict && d_read_ok) |-> src_flash) // R3
    else $error("strict read from wrong source");
  unlock_once_a: assert property (@(posedge sys_clk) disable iff (rst)
    (d_erase_ok && !unlock_wr && mode_ff == FPC_MODE_MID)
    |=> !data_erase_unlock) // R4
    else $error("unlock not consumed by erase");
  erase_start_a: assert property (@(posedge sys_clk) disable iff (rst)
    start_erase |=> self_erase_p) // R7
    else $error("self-erase did not start");
  keep_prot_a: assert property (@(posedge sys_clk) disable iff (rst)
    strap_taken_ff |=> $stable(mode_ff)) // R8
    else $error("mode changed before reset");
  rom_err_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ROM_VARIANT && mode6_req) |=> prot_err_ff && !self_erase_p) // R10
    else $error("no protection error on rom");
  rom_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rom_prot_en && rom_read_ok) |-> fetch_src == FPC_SRC_ROM) // R11
    else $error("rom read from outside rom");
  pw_store_a: assert property (@(posedge sys_clk) disable iff (rst)
    (mode6_req && boot_set_prot && !ROM_VARIANT)
    |=> pw_store && (store_mode == $past(boot_new_mode))) // R5
    else $error("protection enable not stored");
  pw_check_a: assert property (@(posedge sys_clk) disable iff (rst)
    (mode6_req && (boot_pw != stored_pw)) |-> !start_erase) // R6
    else $error("self-erase without password match");
  rom_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
    ROM_VARIANT |-> !p_prog_ok && !p_erase_ok && !start_erase) // R9
    else $error("rom protection lifted");
  busy_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    es_busy |-> !p_prog_ok && !p_erase_ok && !d_prog_ok
    && !d_erase_ok) // R12
    else $error("cpu write granted during self-erase");

endmodule
`default_nettype wire

// File: fpc_host_model.sv
// Far-side model: stored protection settings and flash erase answers.
// Assumes the block's store and self-erase outputs are sys_clk-synchronous.
`timescale 1ns/10ps
`default_nettype none
module fpc_host_model
  import fpc_pkg::*;
#(
  parameter int PW_W = 8
)
(
  input wire logic sys_clk,
  input wire logic pw_store,
  input wire logic [PW_W-1:0] pw_store_val,
  input wire logic [1:0] store_mode,
  input wire logic self_erase_p,
  input wire logic self_erase_d,
  output logic [1:0] strap_mode,
  output logic [PW_W-1:0] stored_pw,
  output logic erase_done
);
  // ------------------------------------------------------------------
  // Non-volatile store
  // ------------------------------------------------------------------
  // Flash contents survive reset, so nothing here is reset
  logic [1:0] mode_ff = 2'h0;
  logic [PW_W-1:0] pw_ff = '0;
  logic [1:0] wait_ff = 2'h0;
  wire erasing = self_erase_p | self_erase_d;
  // Answer each erase step a little late, never in its first cycle
  assign erase_done = erasing & (wait_ff == 2'h1);
  assign strap_mode = mode_ff;
  assign stored_pw = pw_ff;
  always_ff @(posedge sys_clk)
  begin
    wait_ff <= (erasing && !erase_done) ? wait_ff + 2'h1 : 2'h0;
    if (pw_store)
    begin
      mode_ff <= store_mode;
      pw_ff <= pw_store_val;
    end
    else if (self_erase_d && erase_done)
    begin
      mode_ff <= 2'h0;
      pw_ff <= '0;
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the flash protection control block.
// Assumes the host model holds the stored mode and password across resets.
`timescale 1ns/10ps
`default_nettype none
module tb_top import fpc_pkg::*; ;
  logic sys_clk = 1'b0, rst = 1'b1;
  logic [1:0] strap_mode, boot_new_mode, fetch_src, store_mode, prot_mode;
  logic [2:0] boot_mode;
  logic [7:0] boot_new_pw, boot_pw, stored_pw, pw_store_val;
  logic rom_prot_en, boot_req, boot_set_prot, unlock_wr, unlock_val;
  logic erase_done, self_erase_p, self_erase_d, pw_store, prot_err_ff;
  logic data_erase_unlock;
  logic [6:0] req, ok;
  logic [6:0] rom_ok;
  logic rom_err, rom_se, rom_store;
  int n_errors = 0, tests_run = 0;
  fpc_top #(.ROM_VARIANT(1'b0), .PW_W(8)) i_dut (.sys_clk(sys_clk),
    .rst(rst), .strap_mode(strap_mode), .rom_prot_en(rom_prot_en),
    .boot_req(boot_req), .boot_mode(boot_mode), .boot_pw(boot_pw),
    .boot_set_prot(boot_set_prot), .boot_new_mode(boot_new_mode),
    .boot_new_pw(boot_new_pw), .stored_pw(stored_pw),
    .unlock_wr(unlock_wr), .unlock_val(unlock_val), .p_prog_req(req[6]),
    .p_erase_req(req[5]), .d_prog_req(req[4]), .d_erase_req(req[3]),
    .d_read_req(req[2]), .rom_read_req(req[1]), .ext_d_req(req[0]),
    .fetch_src(fetch_src), .erase_done(erase_done), .p_prog_ok(ok[6]),
    .p_erase_ok(ok[5]), .d_prog_ok(ok[4]), .d_erase_ok(ok[3]),
    .d_read_ok(ok[2]), .rom_read_ok(ok[1]), .ext_d_ok(ok[0]),
    .self_erase_p(self_erase_p), .self_erase_d(self_erase_d),
    .pw_store(pw_store), .pw_store_val(pw_store_val),
    .store_mode(store_mode), .prot_err_ff(prot_err_ff),
    .prot_mode(prot_mode), .data_erase_unlock(data_erase_unlock));
  // Same stimulus on a ROM part: its protection can never be lifted
  fpc_top #(.ROM_VARIANT(1'b1), .PW_W(8)) i_dut_rom (.sys_clk(sys_clk),
    .rst(rst), .strap_mode(strap_mode), .rom_prot_en(rom_prot_en),
    .boot_req(boot_req), .boot_mode(boot_mode), .boot_pw(boot_pw),
    .boot_set_prot(boot_set_prot), .boot_new_mode(boot_new_mode),
    .boot_new_pw(boot_new_pw), .stored_pw(stored_pw),
    .unlock_wr(unlock_wr), .unlock_val(unlock_val), .p_prog_req(req[6]),
    .p_erase_req(req[5]), .d_prog_req(req[4]), .d_erase_req(req[3]),
    .d_read_req(req[2]), .rom_read_req(req[1]), .ext_d_req(req[0]),
    .fetch_src(fetch_src), .erase_done(erase_done),
    .p_prog_ok(rom_ok[6]), .p_erase_ok(rom_ok[5]), .d_prog_ok(rom_ok[4]),
    .d_erase_ok(rom_ok[3]), .d_read_ok(rom_ok[2]),
    .rom_read_ok(rom_ok[1]), .ext_d_ok(rom_ok[0]),
    .self_erase_p(rom_se), .self_erase_d(), .pw_store(rom_store),
    .pw_store_val(), .store_mode(), .prot_err_ff(rom_err),
    .prot_mode(), .data_erase_unlock());
  fpc_host_model #(.PW_W(8)) i_host (.sys_clk(sys_clk),
    .pw_store(pw_store), .pw_store_val(pw_store_val),
    .store_mode(store_mode), .self_erase_p(self_erase_p),
    .self_erase_d(self_erase_d), .strap_mode(strap_mode),
    .stored_pw(stored_pw), .erase_done(erase_done));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Mode is taken from the store at the first edge after release
  task automatic do_reset();
    rst = 1'b1;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  // Request held across one edge so a grant can act on state
  task automatic acc(input logic [6:0] r, input logic [1:0] s,
    input logic [6:0] e);
    @(negedge sys_clk);
    req = r;
    fetch_src = s;
    #1;
    chk({1'b0, ok & r}, {1'b0, e});
    @(negedge sys_clk);
    req = 7'h00;
  endtask
  task automatic boot(input logic set, input logic [1:0] m,
    input logic [7:0] pw);
    @(negedge sys_clk);
    boot_req = 1'b1;
    boot_mode = FPC_BOOT_MODE_PROT;
    boot_set_prot = set;
    boot_new_mode = m;
    boot_new_pw = pw;
    boot_pw = pw;
    @(negedge sys_clk);
    boot_req = 1'b0;
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_none();
    rom_prot_en = 1'b0;
    acc(7'h7F, 2'h3, 7'h7E);
    chk(prot_err_ff, 8'h00);
  endtask
  task automatic t_enable(input logic [1:0] m, input logic [7:0] pw);
    boot(1'b1, m, pw);
    chk(pw_store, 8'h01);
    chk(store_mode, m);
    chk(pw_store_val, pw);
    @(negedge sys_clk);
    chk(pw_store, 8'h00);
    do_reset();
    chk(prot_mode, m);
  endtask
  task automatic t_mid();
    acc(7'h7F, 2'h3, 7'h16);
    @(negedge sys_clk);
    unlock_wr = 1'b1;
    @(negedge sys_clk);
    unlock_wr = 1'b0;
    chk(data_erase_unlock, 8'h01);
    acc(7'h08, 2'h3, 7'h08);
    chk(data_erase_unlock, 8'h00);
    acc(7'h08, 2'h3, 7'h00);
  endtask
  task automatic t_strict();
    rom_prot_en = 1'b1;
    acc(7'h7F, 2'h3, 7'h00);
    acc(7'h06, 2'h0, 7'h04);
    acc(7'h06, 2'h1, 7'h04);
    acc(7'h06, 2'h2, 7'h02);
  endtask
  task automatic t_remove(input logic [7:0] pw);
    int i;
    boot(1'b0, 2'h0, pw ^ 8'hFF);
    chk(self_erase_p, 8'h00);
    boot(1'b0, 2'h0, pw);
    chk(self_erase_p, 8'h01);
    acc(7'h40, 2'h3, 7'h00);
    chk(self_erase_d, 8'h01);
    for (i = 0; i < 20 && (self_erase_p | self_erase_d) !== 1'b0; i++)
      @(negedge sys_clk);
    if (i == 20)
    begin
      chk(8'h01, 8'h00);
      give_verdict();
    end
    chk(stored_pw, 8'h00);
    chk(prot_mode, FPC_MODE_STRICT);
    acc(7'h60, 2'h3, 7'h00);
    do_reset();
    chk(prot_mode, FPC_MODE_NONE);
  endtask
  // Runs with the flash part unprotected, so its mode 6 removal starts no self-erase
  task automatic t_rom();
    rom_prot_en = 1'b0;
    @(negedge sys_clk);
    req = 7'h7F;
    fetch_src = 2'h3;
    #1;
    chk({1'b0, rom_ok & req}, 8'h1E);
    @(negedge sys_clk);
    req = 7'h00;
    chk(rom_err, 8'h00);
    boot(1'b0, 2'h0, stored_pw);
    chk(rom_err, 8'h01);
    chk(rom_se, 8'h00);
    boot(1'b1, 2'h1, 8'h77);
    chk(rom_store, 8'h00);
    chk(pw_store, 8'h01);
    do_reset();
    chk(rom_err, 8'h00);
  endtask
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    {boot_new_mode, fetch_src, boot_mode, boot_new_pw, boot_pw} = '0;
    {rom_prot_en, boot_req, boot_set_prot, unlock_wr} = 4'h0;
    unlock_val = 1'b1;
    req = 7'h00;
    do_reset();
    t_none();
    t_enable(FPC_MODE_MID, 8'h3C);
    t_mid();
    t_enable(FPC_MODE_STRICT, 8'h5A);
    t_strict();
    t_remove(8'h5A);
    t_none();
    t_rom();
    give_verdict();
  end
endmodule
`default_nettype wire
